// file: clock_calendar_module_regs.svh
// register offsets, field positions, reset values and timing counts of the rtc control block
`ifndef CLOCK_CALENDAR_MODULE_REGS_SVH
`define CLOCK_CALENDAR_MODULE_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CLOCK_CALENDAR_MODULE_ADDR_W          8
`define CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL  8'h00
`define CLOCK_CALENDAR_MODULE_OFS_ALARM_CTRL  8'h10

// ----------------------------------------------------------------
// clock_control fields
// ----------------------------------------------------------------
`define CLOCK_CALENDAR_MODULE_CC_CAL_HI       25
`define CLOCK_CALENDAR_MODULE_CC_CAL_LO       16
`define CLOCK_CALENDAR_MODULE_CC_ON           15
`define CLOCK_CALENDAR_MODULE_CC_STOP_IN_IDLE         13
`define CLOCK_CALENDAR_MODULE_CC_SEL          7
`define CLOCK_CALENDAR_MODULE_CC_RUN          6
`define CLOCK_CALENDAR_MODULE_CC_WREN         3
`define CLOCK_CALENDAR_MODULE_CC_RSYNC        2
`define CLOCK_CALENDAR_MODULE_CC_HALF         1
`define CLOCK_CALENDAR_MODULE_CC_OE           0

// ----------------------------------------------------------------
// alarm_control fields
// ----------------------------------------------------------------
`define CLOCK_CALENDAR_MODULE_AC_EN           15
`define CLOCK_CALENDAR_MODULE_AC_CHIME        14
`define CLOCK_CALENDAR_MODULE_AC_PIV          13
`define CLOCK_CALENDAR_MODULE_AC_ASYNC        12
`define CLOCK_CALENDAR_MODULE_AC_MASK_HI      11
`define CLOCK_CALENDAR_MODULE_AC_MASK_LO      8
`define CLOCK_CALENDAR_MODULE_AC_RPT_HI       7
`define CLOCK_CALENDAR_MODULE_AC_RPT_LO       0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CLOCK_CALENDAR_MODULE_RST_CAL         10'h000
`define CLOCK_CALENDAR_MODULE_RST_MASK        4'h0
`define CLOCK_CALENDAR_MODULE_RST_RPT         8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_CALENDAR_MODULE_MCLK_NS         50
`define CLOCK_CALENDAR_MODULE_RTC_TICK_NS     30518
`define CLOCK_CALENDAR_MODULE_RTC_DIV         (`CLOCK_CALENDAR_MODULE_RTC_TICK_NS / `CLOCK_CALENDAR_MODULE_MCLK_NS)
`define CLOCK_CALENDAR_MODULE_HALF_TICKS      16384
`define CLOCK_CALENDAR_MODULE_SYNC_WINDOW     32
`define CLOCK_CALENDAR_MODULE_HALVES_PER_MIN  120

`endif

// file: clock_calendar_module_pkg.sv
// types shared by the rtc control block
package clock_calendar_module_pkg;

  // alarm interval codes; codes above year are reserved
  typedef enum logic [3:0] {
    clock_calendar_module_mask_half   = 4'b0000,
    clock_calendar_module_mask_sec    = 4'b0001,
    clock_calendar_module_mask_10sec  = 4'b0010,
    clock_calendar_module_mask_min    = 4'b0011,
    clock_calendar_module_mask_10min  = 4'b0100,
    clock_calendar_module_mask_hour   = 4'b0101,
    clock_calendar_module_mask_day    = 4'b0110,
    clock_calendar_module_mask_week   = 4'b0111,
    clock_calendar_module_mask_month  = 4'b1000,
    clock_calendar_module_mask_year   = 4'b1001
  } clock_calendar_module_mask_t;

endpackage : clock_calendar_module_pkg

// file: clock_calendar_module_match.sv
// alarm comparator: current calendar against alarm fields under the interval mask
`timescale 1ns/1ns
`include "clock_calendar_module_regs.svh"
module clock_calendar_module_match import clock_calendar_module_pkg::*; (
  input  wire logic [31:0] cur_time,
  input  wire logic [31:0] cur_date,
  input  wire logic [31:0] alarm_time,
  input  wire logic [31:0] alarm_date,
  input  wire logic [3:0]  interval_mask,
  input  wire logic        second_edge,
  output logic             match
);

  logic sec01_eq;
  logic sec_eq;
  logic min01_eq;
  logic min_eq;
  logic hour_eq;
  logic wday_eq;
  logic day_eq;
  logic month_eq;

  // field compares, each one widening a narrower one; weekday and day both widen the hour compare
  assign sec01_eq = cur_time[11:8] == alarm_time[11:8];
  assign sec_eq   = cur_time[14:8] == alarm_time[14:8];
  assign min01_eq = sec_eq && (cur_time[19:16] == alarm_time[19:16]);
  assign min_eq   = sec_eq && (cur_time[22:16] == alarm_time[22:16]);
  assign hour_eq  = min_eq && (cur_time[29:24] == alarm_time[29:24]);
  assign wday_eq  = hour_eq && (cur_date[2:0] == alarm_date[2:0]);
  assign day_eq   = hour_eq && (cur_date[13:8] == alarm_date[13:8]);
  assign month_eq = day_eq && (cur_date[20:16] == alarm_date[20:16]);

  // mask decode; a feb 29 alarm only matches in leap years by itself
  always_comb begin
    case (clock_calendar_module_mask_t'(interval_mask))
      clock_calendar_module_mask_half:  match = 1'b1;
      clock_calendar_module_mask_sec:   match = second_edge;
      clock_calendar_module_mask_10sec: match = second_edge && sec01_eq;
      clock_calendar_module_mask_min:   match = second_edge && sec_eq;
      clock_calendar_module_mask_10min: match = second_edge && min01_eq;
      clock_calendar_module_mask_hour:  match = second_edge && min_eq;
      clock_calendar_module_mask_day:   match = second_edge && hour_eq;
      clock_calendar_module_mask_week:  match = second_edge && wday_eq;
      clock_calendar_module_mask_month: match = second_edge && day_eq;
      clock_calendar_module_mask_year:  match = second_edge && month_eq;
      default:         match = 1'b0; // reserved codes never fire
    endcase
  end

endmodule : clock_calendar_module_match

// file: clock_calendar_module_ctrl.sv
// rtc control, calibration and alarm setup block with its register port
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "clock_calendar_module_regs.svh"
module clock_calendar_module_ctrl import clock_calendar_module_pkg::*; #(
  parameter int HALF_TICKS = `CLOCK_CALENDAR_MODULE_HALF_TICKS
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [`CLOCK_CALENDAR_MODULE_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [31:0]             rd_data,
  input  wire logic                    sys_unlock,
  input  wire logic                    idle_mode,
  input  wire logic                    sec_write,
  input  wire logic [31:0]             cur_time,
  input  wire logic [31:0]             cur_date,
  input  wire logic [31:0]             alarm_time,
  input  wire logic [31:0]             alarm_date,
  output logic                         value_write_enable,
  output logic                         bus_clock_enable,
  output logic                         sec_tick,
  output logic                         alarm_event,
  output logic                         pin_out,
  output logic                         pin_oe
);

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam logic [15:0] RTC_DIV     = 16'(`CLOCK_CALENDAR_MODULE_RTC_DIV);
  localparam logic [15:0] HALF_LIMIT  = 16'(HALF_TICKS);
  localparam logic [15:0] SYNC_START  = 16'(HALF_TICKS - `CLOCK_CALENDAR_MODULE_SYNC_WINDOW);
  localparam logic [6:0]  LAST_HALF   = 7'(`CLOCK_CALENDAR_MODULE_HALVES_PER_MIN - 1);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [9:0]  cal;
  logic        module_on;
  logic        stop_in_idle;
  logic        output_source_select;
  logic        clock_running_status;
  logic        wren;
  logic        value_read_sync;
  logic        half_second_status;
  logic        pin_output_enable;
  logic        alarm_enable;
  logic        chime;
  logic        pulse_level;
  logic        alarm_read_sync;
  logic [3:0]  alarm_interval_mask;
  logic [7:0]  alarm_repeat_count;

  // ----------------------------------------------------------------
  // timekeeping state
  // ----------------------------------------------------------------
  logic [15:0]       div_cnt;
  logic              rtc_tick;
  logic [15:0]       prescaler;
  logic [6:0]        half_count;
  logic signed [10:0] cal_pending;
  logic [15:0]       step;
  logic [15:0]       next_prescaler;
  logic              half_rollover;
  logic              match;
  logic              fire;

  // write decodes
  logic wr_clock;
  logic wr_alarm;

  assign wr_clock = wr_en && (addr == `CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL);
  assign wr_alarm = wr_en && (addr == `CLOCK_CALENDAR_MODULE_OFS_ALARM_CTRL);

  // ----------------------------------------------------------------
  // rtc clock enable from the master clock divider
  // ----------------------------------------------------------------

  // the divider stops with the module so a disabled block draws no ticks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt  <= 16'h0000;
      rtc_tick <= 1'b0;
    end else if (!module_on) begin
      div_cnt  <= 16'h0000;
      rtc_tick <= 1'b0;
    end else if (div_cnt == RTC_DIV - 16'h0001) begin
      div_cnt  <= 16'h0000;
      rtc_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 16'h0001;
      rtc_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // drift calibration and half-second prescaler
  // ----------------------------------------------------------------

  // positive pending count doubles a tick, negative swallows a tick
  always_comb begin
    if (cal_pending > 11'sd0) begin
      step = 16'h0002;
    end else if (cal_pending < 11'sd0) begin
      step = 16'h0000;
    end else begin
      step = 16'h0001;
    end
    next_prescaler = prescaler + step;
    half_rollover  = rtc_tick && (next_prescaler >= HALF_LIMIT);
  end

  // prescaler; a seconds write restarts the second from its first half
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prescaler <= 16'h0000;
    end else if (sec_write) begin
      prescaler <= 16'h0000;
    end else if (half_rollover) begin
      prescaler <= next_prescaler - HALF_LIMIT;
    end else if (rtc_tick) begin
      prescaler <= next_prescaler;
    end
  end

  // half-second status and minute counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      half_second_status <= 1'b0;
      half_count         <= 7'h00;
    end else if (sec_write) begin
      half_second_status <= 1'b0;
    end else if (half_rollover) begin
      half_second_status <= !half_second_status;
      half_count         <= (half_count == LAST_HALF) ? 7'h00 : half_count + 7'h01;
    end
  end

  // correction loaded once a minute and spent one tick at a time
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_pending <= 11'sd0;
    end else if (half_rollover && half_count == LAST_HALF) begin
      cal_pending <= signed'({cal[9], cal});
    end else if (rtc_tick && cal_pending > 11'sd0) begin
      cal_pending <= cal_pending - 11'sd1;
    end else if (rtc_tick && cal_pending < 11'sd0) begin
      cal_pending <= cal_pending + 11'sd1;
    end
  end

  // seconds tick to the calendar at the end of each second's second half
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= half_rollover && half_second_status;
    end
  end

  // ----------------------------------------------------------------
  // read synchronisation windows
  // ----------------------------------------------------------------

  // flags raised within the last ticks before a rollover; software rereads
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alarm_read_sync <= 1'b0;
      value_read_sync <= 1'b0;
    end else begin
      alarm_read_sync <= module_on && (prescaler >= SYNC_START);
      value_read_sync <= module_on && half_second_status && (prescaler >= SYNC_START);
    end
  end

  // ----------------------------------------------------------------
  // clock status and idle gating
  // ----------------------------------------------------------------

  // running only once the first tick has actually been seen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clock_running_status <= 1'b0;
    end else if (!module_on) begin
      clock_running_status <= 1'b0;
    end else if (rtc_tick) begin
      clock_running_status <= 1'b1;
    end
  end

  // bus clock gate request; timekeeping itself keeps running in idle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_clock_enable <= 1'b1;
    end else begin
      bus_clock_enable <= !(idle_mode && stop_in_idle);
    end
  end

  // ----------------------------------------------------------------
  // clock_control register
  // ----------------------------------------------------------------

  // plain control fields
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal                  <= `CLOCK_CALENDAR_MODULE_RST_CAL;
      stop_in_idle         <= 1'b0;
      output_source_select <= 1'b0;
      pin_output_enable    <= 1'b0;
    end else if (wr_clock) begin
      cal                  <= wr_data[`CLOCK_CALENDAR_MODULE_CC_CAL_HI:`CLOCK_CALENDAR_MODULE_CC_CAL_LO];
      stop_in_idle         <= wr_data[`CLOCK_CALENDAR_MODULE_CC_STOP_IN_IDLE];
      output_source_select <= wr_data[`CLOCK_CALENDAR_MODULE_CC_SEL];
      pin_output_enable    <= wr_data[`CLOCK_CALENDAR_MODULE_CC_OE];
    end
  end

  // module enable is guarded by the value write enable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      module_on <= 1'b0;
    end else if (wr_clock && wren) begin
      module_on <= wr_data[`CLOCK_CALENDAR_MODULE_CC_ON];
    end
  end

  // write enable sets only under system unlock, clears freely
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wren <= 1'b0;
    end else if (wr_clock && (sys_unlock || !wr_data[`CLOCK_CALENDAR_MODULE_CC_WREN])) begin
      wren <= wr_data[`CLOCK_CALENDAR_MODULE_CC_WREN];
    end
  end

  // lock output to the value registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      value_write_enable <= 1'b0;
    end else begin
      value_write_enable <= wren;
    end
  end

  // ----------------------------------------------------------------
  // alarm matching and alarm_control register
  // ----------------------------------------------------------------

  clock_calendar_module_match u_match (
    .cur_time      (cur_time),
    .cur_date      (cur_date),
    .alarm_time    (alarm_time),
    .alarm_date    (alarm_date),
    .interval_mask (alarm_interval_mask),
    .second_edge   (half_second_status),
    .match         (match)
  );

  // alarms are only evaluated on half-second boundaries
  assign fire = half_rollover && alarm_enable && match;

  // enable and chime; a software write in the same cycle wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alarm_enable <= 1'b0;
      chime        <= 1'b0;
    end else if (wr_alarm) begin
      alarm_enable <= wr_data[`CLOCK_CALENDAR_MODULE_AC_EN];
      chime        <= wr_data[`CLOCK_CALENDAR_MODULE_AC_CHIME];
    end else if (fire && alarm_repeat_count == 8'h00 && !chime) begin
      alarm_enable <= 1'b0;
    end
  end

  // mask field
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alarm_interval_mask <= `CLOCK_CALENDAR_MODULE_RST_MASK;
    end else if (wr_alarm) begin
      alarm_interval_mask <= wr_data[`CLOCK_CALENDAR_MODULE_AC_MASK_HI:`CLOCK_CALENDAR_MODULE_AC_MASK_LO];
    end
  end

  // repeat counter: wraps only with chime, otherwise parks at zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alarm_repeat_count <= `CLOCK_CALENDAR_MODULE_RST_RPT;
    end else if (wr_alarm) begin
      alarm_repeat_count <= wr_data[`CLOCK_CALENDAR_MODULE_AC_RPT_HI:`CLOCK_CALENDAR_MODULE_AC_RPT_LO];
    end else if (fire && (alarm_repeat_count != 8'h00 || chime)) begin
      alarm_repeat_count <= alarm_repeat_count - 8'h01;
    end
  end

  // pulse level: preset while disabled, toggled by each alarm event
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulse_level <= 1'b0;
    end else if (wr_alarm && !alarm_enable) begin
      pulse_level <= wr_data[`CLOCK_CALENDAR_MODULE_AC_PIV];
    end else if (fire) begin
      pulse_level <= !pulse_level;
    end
  end

  // one-cycle event strobe for the rest of the chip
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alarm_event <= 1'b0;
    end else begin
      alarm_event <= fire;
    end
  end

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------

  // low while disabled so the pad never floats at a stale level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_oe  <= pin_output_enable;
      pin_out <= pin_output_enable &&
                 (output_source_select ? half_second_status : pulse_level);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------

  // data stand one cycle after the strobe; unmapped or idle reads give zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en && addr == `CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL) begin
      rd_data <= {6'h00, cal, module_on, 1'b0, stop_in_idle, 5'h00,
                  output_source_select, clock_running_status, 2'h0, wren,
                  value_read_sync, half_second_status, pin_output_enable};
    end else if (rd_en && addr == `CLOCK_CALENDAR_MODULE_OFS_ALARM_CTRL) begin
      rd_data <= {16'h0000, alarm_enable, chime, pulse_level, alarm_read_sync,
                  alarm_interval_mask, alarm_repeat_count};
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

endmodule : clock_calendar_module_ctrl

// file: clock_calendar_module_ctrl_chk.sv
// port-level assertions for the rtc control block
`timescale 1ns/1ns
`include "clock_calendar_module_regs.svh"
module clock_calendar_module_ctrl_chk import clock_calendar_module_pkg::*; (
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic [`CLOCK_CALENDAR_MODULE_ADDR_W-1:0] addr,
  input wire logic [31:0]             wr_data,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [31:0]             rd_data,
  input wire logic                    sys_unlock,
  input wire logic                    idle_mode,
  input wire logic                    value_write_enable,
  input wire logic                    bus_clock_enable,
  input wire logic                    sec_tick,
  input wire logic                    alarm_event,
  input wire logic                    pin_out,
  input wire logic                    pin_oe
);
  // ----------------------------------------------------------------
  // shadow of the control bits
  // ----------------------------------------------------------------
  logic cc_wr;
  logic wren_sh;
  logic on_sh;
  logic oe_sh;
  logic oe_d;
  logic stop_in_idle_sh;

  assign cc_wr = wr_en && addr == `CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL;

  // mirrors the lock chain so reads can be judged without the body
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wren_sh <= 1'b0;
      on_sh   <= 1'b0;
      oe_sh   <= 1'b0;
      stop_in_idle_sh <= 1'b0;
      oe_d    <= 1'b0;
    end else begin
      oe_d <= oe_sh;
      if (cc_wr) begin
        wren_sh <= wr_data[3] & (sys_unlock | wren_sh);
        oe_sh   <= wr_data[0];
        stop_in_idle_sh <= wr_data[13];
        if (wren_sh) begin
          on_sh <= wr_data[15];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_pin_quiet: assert property (!pin_oe |-> !pin_out)
    else $error("pin high while output disabled");
  a_oe_follow: assert property (pin_oe == oe_d)
    else $error("pin enable does not follow its bit");
  a_idle_gate: assert property (bus_clock_enable == !($past(idle_mode) && $past(stop_in_idle_sh)))
    else $error("bus clock gating wrong for idle state");
  a_wren_unlock: assert property ($rose(value_write_enable) |->
    ($past(wr_en) && $past(sys_unlock)) || ($past(wr_en, 2) && $past(sys_unlock, 2)))
    else $error("write enable set without unlock");
  a_rd_wren: assert property (rd_en && addr == `CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL |=> rd_data[3] == $past(wren_sh))
    else $error("write enable bit reads wrong");
  a_rd_on: assert property (rd_en && addr == `CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL |=> rd_data[15] == $past(on_sh))
    else $error("module enable bit reads wrong");
  a_off_quiet: assert property (!on_sh [*3] |-> !alarm_event && !sec_tick)
    else $error("event while module disabled");
  a_evt_single: assert property (alarm_event |=> !alarm_event)
    else $error("alarm event longer than one cycle");
  a_tick_single: assert property (sec_tick |=> !sec_tick [*8])
    else $error("seconds tick repeats too soon");
endmodule : clock_calendar_module_ctrl_chk

bind clock_calendar_module_ctrl clock_calendar_module_ctrl_chk clock_calendar_module_ctrl_chk_i (.mclk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
  .sys_unlock, .idle_mode, .value_write_enable, .bus_clock_enable, .sec_tick, .alarm_event, .pin_out, .pin_oe);

// file: test_clock_calendar_module_ctrl.sv
// self-checking testbench of the rtc control block
`timescale 1ns/1ns
`include "clock_calendar_module_regs.svh"
module test_clock_calendar_module_ctrl import clock_calendar_module_pkg::*; ();
  localparam int HT = 34;   // shortened half second, must stay above 32
  localparam int DIV = `CLOCK_CALENDAR_MODULE_RTC_DIV;
  localparam int HALF_CYC = HT * DIV;
  localparam int LIMIT = 4 * HALF_CYC + 5000;
  localparam logic [7:0] CC = `CLOCK_CALENDAR_MODULE_OFS_CLOCK_CTRL;
  localparam logic [7:0] AC = `CLOCK_CALENDAR_MODULE_OFS_ALARM_CTRL;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        sys_unlock = 1'b0;
  logic        idle_mode = 1'b0;
  logic        sec_write = 1'b0;
  logic [31:0] rd_data;
  logic        vwe;
  logic        bce;
  logic        sec_tick;
  logic        alarm_event;
  logic        pin_out;
  logic        pin_oe;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  clock_calendar_module_ctrl #(.HALF_TICKS(HT)) clock_calendar_module_ctrl_i (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .sys_unlock(sys_unlock), .idle_mode(idle_mode), .sec_write(sec_write),
    .cur_time(32'h0), .cur_date(32'h0), .alarm_time(32'h0), .alarm_date(32'h0),
    .value_write_enable(vwe), .bus_clock_enable(bce), .sec_tick(sec_tick),
    .alarm_event(alarm_event), .pin_out(pin_out), .pin_oe(pin_oe));

  // free-running 20 MHz clock
  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------
  // bench tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // bounded wait, an alarm is due within two half seconds
  task automatic wait_evt(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 2 * HALF_CYC && !seen; i++) begin
      @(posedge mclk);
      #1 seen = alarm_event;
    end
  endtask : wait_evt

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lock();
    logic [31:0] d;
    rd(CC, d);
    chk("clock_control reset", 32'h0, d);
    chk("bus clock after reset", 32'h1, 32'(bce));
    wr(CC, 32'h8000);
    rd(CC, d);
    chk("enable bit locked", 32'h0, 32'(d[15]));
    wr(CC, 32'h8);
    cyc(1);
    chk("write enable while locked", 32'h0, 32'(vwe));
    @(posedge mclk);
    sys_unlock <= 1'b1;
    wr(CC, 32'h8);
    cyc(1);
    chk("write enable unlocked", 32'h1, 32'(vwe));
    @(posedge mclk);
    sys_unlock <= 1'b0;
    rd(8'h04, d);
    chk("unmapped read", 32'h0, d);
    $display("test lock done");
  endtask : t_lock

  task automatic t_idle();
    wr(CC, 32'h2008);
    @(posedge mclk);
    idle_mode <= 1'b1;
    cyc(2);
    chk("bus clock in idle", 32'h0, 32'(bce));
    wr(CC, 32'h8);
    cyc(2);
    chk("bus clock kept", 32'h1, 32'(bce));
    @(posedge mclk);
    idle_mode <= 1'b0;
    $display("test idle done");
  endtask : t_idle

  task automatic t_piv();
    logic [31:0] d;
    wr(AC, 32'h2000);
    rd(AC, d);
    chk("pulse initial value", 32'h1, 32'(d[13]));
    wr(CC, 32'h9);
    cyc(2);
    chk("pin shows pulse", 32'h1, 32'(pin_out));
    chk("pin enabled", 32'h1, 32'(pin_oe));
    wr(CC, 32'h8);
    cyc(2);
    chk("pin released", 32'h0, 32'(pin_out));
    $display("test pulse value done");
  endtask : t_piv

  // one repeat: two alarms, the last one disarms the alarm
  task automatic t_alarm();
    logic [31:0] d;
    logic        seen;
    wr(AC, {20'h0000a, clock_calendar_module_mask_half, 8'h01});
    wr(AC, {20'h00008, clock_calendar_module_mask_half, 8'h01});
    rd(AC, d);
    chk("pulse bit read only", 32'h1, 32'(d[13]));
    wr(CC, 32'h8089);
    cyc(DIV + 20);
    rd(CC, d);
    chk("clock running", 32'h1, 32'(d[6]));
    wait_evt(seen);
    chk("first alarm", 32'h1, 32'(seen));
    chk("no seconds tick on half", 32'h0, 32'(sec_tick));
    rd(AC, d);
    chk("after first alarm", 32'h8000, d & 32'hdfff);
    chk("seconds clock on pin", 32'h1, 32'(pin_out));
    cyc(3 * DIV);
    rd(AC, d);
    chk("alarm sync near rollover", 32'h1, 32'(d[12]));
    rd(AC, d);
    chk("repeat count reread", 32'h0, 32'(d[7:0]));
    rd(CC, d);
    chk("half second", 32'h1, 32'(d[1]));
    chk("read sync", 32'h1, 32'(d[2]));
    rd(CC, d);
    chk("half second reread", 32'h1, 32'(d[1]));
    @(posedge mclk);
    sec_write <= 1'b1;
    @(posedge mclk);
    sec_write <= 1'b0;
    rd(CC, d);
    chk("half cleared by seconds write", 32'h0, 32'(d[1]));
    wait_evt(seen);
    chk("last alarm", 32'h1, 32'(seen));
    rd(AC, d);
    chk("alarm disarmed", 32'h0, d & 32'hdfff);
    $display("test alarm done");
  endtask : t_alarm

  // chime wraps the count instead of disarming
  task automatic t_chime();
    logic [31:0] d;
    logic        seen;
    wr(AC, {20'h0000c, clock_calendar_module_mask_sec, 8'h00});
    wait_evt(seen);
    chk("chime alarm", 32'h1, 32'(seen));
    chk("seconds tick with alarm", 32'h1, 32'(sec_tick));
    rd(AC, d);
    chk("count wrapped", 32'hc1ff, d & 32'hdfff);
    wr(AC, 32'h0);
    wr(CC, 32'h8);
    cyc(3);
    rd(CC, d);
    chk("clock stopped", 32'h0, 32'(d[6]));
    $display("test chime done");
  endtask : t_chime

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("Error run length expected finish seen timeout");
      end_of_test();
    end
  end

  // reset then the scenarios in turn
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_lock();
    t_idle();
    t_piv();
    t_alarm();
    t_chime();
    end_of_test();
  end
endmodule : test_clock_calendar_module_ctrl
